// File: strap_cfg_pkg.sv
// Constants shared by the strap configuration latch.
// Assumes a 32-bit classic Wishbone slave port and a 16-bit register map.
package strap_cfg_pkg;

  // ****************************************************************
  // Strap vector layout (one bit per strap pin)
  // ****************************************************************
  localparam int unsigned STRAP_W = 12;
  localparam int unsigned SP_ADDR_LSB = 0;
  localparam int unsigned SP_ADDR_W = 3;
  localparam int unsigned SP_BCAST = 3;
  localparam int unsigned SP_MODE_LSB = 4;
  localparam int unsigned SP_MODE_W = 3;
  localparam int unsigned SP_ISO = 7;
  localparam int unsigned SP_SPEED = 8;
  localparam int unsigned SP_DUPLEX = 9;
  localparam int unsigned SP_ANEG = 10;
  localparam int unsigned SP_NAND_N = 11;
  // Levels left by the internal pulls alone: address 1, RMII, 100M,
  // half duplex, auto-negotiation on, test mode off
  localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 12'hF11;

  // ****************************************************************
  // Interface mode codes
  // ****************************************************************
  localparam logic [SP_MODE_W-1:0] MODE_RMII = 3'h1;
  localparam logic [SP_MODE_W-1:0] MODE_B2B = 3'h5;

  // ****************************************************************
  // Register map: index, byte address is four times the index
  // ****************************************************************
  localparam int unsigned IDX_W = 6;
  localparam int unsigned ADR_LSB = 2;
  localparam logic [IDX_W-1:0] IDX_BASIC_CTRL = 6'h00;
  localparam logic [IDX_W-1:0] IDX_AN_ADV = 6'h04;
  localparam logic [IDX_W-1:0] IDX_PHY_CTRL = 6'h16;
  localparam logic [IDX_W-1:0] IDX_STRAP_STAT = 6'h18;
  localparam int unsigned REG_W = 16;

  localparam int unsigned CTRL_SPEED = 13;
  localparam int unsigned CTRL_ANEG = 12;
  localparam int unsigned CTRL_ISO = 10;
  localparam int unsigned CTRL_DUPLEX = 8;
  localparam logic [REG_W-1:0] CTRL_RESET = 16'h3000;

  localparam logic [REG_W-1:0] ADV_RESET = 16'h01E1;
  localparam logic [REG_W-1:0] ADV_100_MASK = 16'h0180;

  localparam int unsigned PCTL_BCAST_OFF = 9;
  localparam logic [REG_W-1:0] PCTL_RESET = 16'h0000;

  // Strap status register fields
  localparam int unsigned STAT_VALID = 15;
  localparam int unsigned STAT_RSVD_MODE = 14;

endpackage : strap_cfg_pkg

// File: reset_strap_config_latch.sv
// Reset-time strap capture and control-register preload for the PHY.
// Assumes chip_rst_n_i and the strap pads are asynchronous to clk_i;
// func_i comes from the PHY's own logic on clk_i.
`timescale 1ns/1ps

// Contract
// R1 - Straps sampled once at chip reset release, held until next reset.
// R2 - Three strapped address bits select 0 to 7; pulls alone give 1.
// R3 - Address 0 is broadcast unless strap high or bit 9 of 16h set.
// R4 - Upper two management address bits are fixed internally.
// R5 - Mode code 001 is RMII, 101 back-to-back; others reserved.
// R6 - Isolate strap loads control bit 10; high enables isolate.
// R7 - Speed strap loads control bit 13 and advertised 100M ability.
// R8 - Duplex strap loads control bit 8; high means half duplex.
// R9 - Auto-negotiation strap loads control bit 12; high enables it.
// R10 - Test-mode strap captured; low enables NAND-tree mode.
// R11 - Strap pins are pulled inputs in reset, outputs after release.
// R12 - MAC avoids driving strap pins in reset, else board adds pulls.
// R13 - Chip reset is active low; capture on its rising edge.
module reset_strap_config_latch #(
  parameter logic [1:0] ADDR_HI = 2'h0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic chip_rst_n_i,
  input wire logic [strap_cfg_pkg::STRAP_W-1:0] strap_pin_i,
  output logic [strap_cfg_pkg::STRAP_W-1:0] strap_pin_o,
  output logic [strap_cfg_pkg::STRAP_W-1:0] strap_pin_oe_o,
  output logic pull_en_o,
  input wire logic [strap_cfg_pkg::STRAP_W-1:0] func_i,
  output logic cfg_valid_o,
  output logic [4:0] mgmt_addr_o,
  output logic bcast_en_o,
  output logic rmii_mode_o,
  output logic b2b_mode_o,
  output logic mode_reserved_o,
  output logic isolate_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic autoneg_en_o,
  output logic nand_tree_en_o
);

  localparam int unsigned SW = strap_cfg_pkg::STRAP_W;
  localparam int unsigned RW = strap_cfg_pkg::REG_W;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [strap_cfg_pkg::SP_MODE_W-1:0] mode_of(
    input logic [SW-1:0] s
  );
    mode_of = s[strap_cfg_pkg::SP_MODE_LSB +: strap_cfg_pkg::SP_MODE_W];
  endfunction : mode_of

  function automatic logic [RW-1:0] lane_merge(
    input logic [RW-1:0] old_v,
    input logic [31:0] wd,
    input logic [3:0] sel
  );
    lane_merge = old_v;
    if (sel[0]) begin
      lane_merge[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      lane_merge[15:8] = wd[15:8];
    end
  endfunction : lane_merge

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic rstn_meta_ff;
  logic rstn_sync_ff;
  logic rstn_prev_ff;
  logic [SW-1:0] strap_meta_ff;
  logic [SW-1:0] strap_sync_ff;
  logic capture;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rstn_meta_ff <= 1'b0;
      rstn_sync_ff <= 1'b0;
      rstn_prev_ff <= 1'b0;
    end else begin
      rstn_meta_ff <= chip_rst_n_i;
      rstn_sync_ff <= rstn_meta_ff;
      rstn_prev_ff <= rstn_sync_ff;
    end
  end

  // Pads share the reset path depth, so the level seen at the capture
  // edge is the one present when the reset pin rose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_meta_ff <= strap_cfg_pkg::STRAP_DEFAULT;
      strap_sync_ff <= strap_cfg_pkg::STRAP_DEFAULT;
    end else begin
      strap_meta_ff <= strap_pin_i;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // R13 rising edge
  assign capture = rstn_sync_ff && !rstn_prev_ff;

  // ****************************************************************
  // Captured straps
  // ****************************************************************
  logic [SW-1:0] strap_ff;
  logic cfg_valid_ff;

  // R1 one-shot capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_ff <= strap_cfg_pkg::STRAP_DEFAULT;
    end else if (capture) begin
      strap_ff <= strap_sync_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_valid_ff <= 1'b0;
    end else if (!rstn_sync_ff) begin
      cfg_valid_ff <= 1'b0;
    end else if (capture) begin
      cfg_valid_ff <= 1'b1;
    end
  end

  // ****************************************************************
  // Pad direction
  // ****************************************************************
  logic [SW-1:0] pin_o_ff;
  logic [SW-1:0] pin_oe_ff;
  logic pull_en_ff;

  // R11 pulled input in reset, output after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_oe_ff <= '0;
      pull_en_ff <= 1'b1;
      pin_o_ff <= '0;
    end else begin
      pin_oe_ff <= {SW{cfg_valid_ff && rstn_sync_ff}};
      pull_en_ff <= !(cfg_valid_ff && rstn_sync_ff);
      pin_o_ff <= func_i;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [RW-1:0] ctrl_ff;
  logic [RW-1:0] adv_ff;
  localparam int unsigned IDX_W_L = strap_cfg_pkg::IDX_W;

  logic [RW-1:0] pctl_ff;
  logic [IDX_W_L-1:0] idx;
  logic wr_req;
  logic [RW-1:0] nxt_adv_load;

  assign idx = adr_i[strap_cfg_pkg::ADR_LSB +: IDX_W_L];
  // Writes land on the acknowledging edge, where the master sees ack
  assign wr_req = cyc_i && stb_i && we_i && ack_o;

  // R7 advertised speed follows the strap
  always_comb begin
    nxt_adv_load = strap_cfg_pkg::ADV_RESET;
    if (!strap_sync_ff[strap_cfg_pkg::SP_SPEED]) begin
      nxt_adv_load = strap_cfg_pkg::ADV_RESET & ~strap_cfg_pkg::ADV_100_MASK;
    end
  end

  // Capture outranks a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= strap_cfg_pkg::CTRL_RESET;
    end else if (capture) begin
      // R6 isolate bit
      ctrl_ff[strap_cfg_pkg::CTRL_ISO] <=
        strap_sync_ff[strap_cfg_pkg::SP_ISO];
      // R7 speed bit
      ctrl_ff[strap_cfg_pkg::CTRL_SPEED] <=
        strap_sync_ff[strap_cfg_pkg::SP_SPEED];
      // R8 duplex bit, set means full duplex
      ctrl_ff[strap_cfg_pkg::CTRL_DUPLEX] <=
        !strap_sync_ff[strap_cfg_pkg::SP_DUPLEX];
      // R9 auto-negotiation bit
      ctrl_ff[strap_cfg_pkg::CTRL_ANEG] <=
        strap_sync_ff[strap_cfg_pkg::SP_ANEG];
    end else if (wr_req && idx == strap_cfg_pkg::IDX_BASIC_CTRL) begin
      ctrl_ff <= lane_merge(ctrl_ff, dat_i, sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adv_ff <= strap_cfg_pkg::ADV_RESET;
    end else if (capture) begin
      adv_ff <= nxt_adv_load;
    end else if (wr_req && idx == strap_cfg_pkg::IDX_AN_ADV) begin
      adv_ff <= lane_merge(adv_ff, dat_i, sel_i);
    end
  end

  // Software bit 9 survives chip reset; only rst_i or a write to 16h clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pctl_ff <= strap_cfg_pkg::PCTL_RESET;
    end else if (wr_req && idx == strap_cfg_pkg::IDX_PHY_CTRL) begin
      pctl_ff <= lane_merge(pctl_ff, dat_i, sel_i);
    end
  end

  // ****************************************************************
  // Wishbone answer: one wait state, unmapped reads return zero
  // ****************************************************************
  logic [31:0] rd_data;

  always_comb begin
    rd_data = '0;
    unique case (idx)
      strap_cfg_pkg::IDX_BASIC_CTRL: rd_data[RW-1:0] = ctrl_ff;
      strap_cfg_pkg::IDX_AN_ADV: rd_data[RW-1:0] = adv_ff;
      strap_cfg_pkg::IDX_PHY_CTRL: rd_data[RW-1:0] = pctl_ff;
      strap_cfg_pkg::IDX_STRAP_STAT: begin
        rd_data[SW-1:0] = strap_ff;
        rd_data[strap_cfg_pkg::STAT_RSVD_MODE] = mode_reserved_o;
        rd_data[strap_cfg_pkg::STAT_VALID] = cfg_valid_ff;
      end
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= rd_data;
    end
  end

  // ****************************************************************
  // Configuration outputs
  // ****************************************************************
  logic [strap_cfg_pkg::SP_MODE_W-1:0] mode_cur;
  assign mode_cur = mode_of(strap_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mgmt_addr_o <= {ADDR_HI, strap_cfg_pkg::STRAP_DEFAULT[
        strap_cfg_pkg::SP_ADDR_LSB +: strap_cfg_pkg::SP_ADDR_W]};
      bcast_en_o <= 1'b1;
      rmii_mode_o <= 1'b1;
      b2b_mode_o <= 1'b0;
      mode_reserved_o <= 1'b0;
      nand_tree_en_o <= 1'b0;
    end else begin
      // R2 R4 fixed upper bits, strapped lower bits
      mgmt_addr_o <= {ADDR_HI,
        strap_ff[strap_cfg_pkg::SP_ADDR_LSB +: strap_cfg_pkg::SP_ADDR_W]};
      // R3 broadcast on address 0
      bcast_en_o <= !strap_ff[strap_cfg_pkg::SP_BCAST] &&
        !pctl_ff[strap_cfg_pkg::PCTL_BCAST_OFF];
      // R5 mode decode
      rmii_mode_o <= mode_cur == strap_cfg_pkg::MODE_RMII;
      b2b_mode_o <= mode_cur == strap_cfg_pkg::MODE_B2B;
      mode_reserved_o <= mode_cur != strap_cfg_pkg::MODE_RMII &&
        mode_cur != strap_cfg_pkg::MODE_B2B;
      // R10 active-low test strap
      nand_tree_en_o <= !strap_ff[strap_cfg_pkg::SP_NAND_N];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isolate_o <= 1'b0;
      speed_100_o <= 1'b1;
      full_duplex_o <= 1'b0;
      autoneg_en_o <= 1'b1;
    end else begin
      isolate_o <= ctrl_ff[strap_cfg_pkg::CTRL_ISO];
      speed_100_o <= ctrl_ff[strap_cfg_pkg::CTRL_SPEED];
      full_duplex_o <= ctrl_ff[strap_cfg_pkg::CTRL_DUPLEX];
      autoneg_en_o <= ctrl_ff[strap_cfg_pkg::CTRL_ANEG];
    end
  end

  assign cfg_valid_o = cfg_valid_ff;
  assign strap_pin_o = pin_o_ff;
  assign strap_pin_oe_o = pin_oe_ff;
  assign pull_en_o = pull_en_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_strap_hold_stable: assert property ( // R1
    !capture |=> strap_ff == $past(strap_ff)
  ) else $error("Captured straps changed without a reset release");

  a_addr_low_bits: assert property ( // R2
    capture |=> ##1 mgmt_addr_o[2:0] == $past(strap_sync_ff[2:0], 2)
  ) else $error("Management address does not follow the strap");

  a_bcast_gate_path: assert property ( // R3
    ##1 bcast_en_o == ($past(!strap_ff[strap_cfg_pkg::SP_BCAST]) &&
      $past(!pctl_ff[strap_cfg_pkg::PCTL_BCAST_OFF]))
  ) else $error("Broadcast enable wrong");

  a_addr_hi_fixed: assert property ( // R4
    mgmt_addr_o[4:3] == ADDR_HI
  ) else $error("Upper address bits not fixed");

  a_mode_decode_one: assert property ( // R5
    ##2 $onehot({rmii_mode_o, b2b_mode_o, mode_reserved_o})
  ) else $error("Mode decode not one-hot");

  a_ctrl_load_ok: assert property ( // R6 R7 R8 R9
    capture |=> ctrl_ff[strap_cfg_pkg::CTRL_ISO] ==
      $past(strap_sync_ff[strap_cfg_pkg::SP_ISO]) &&
      ctrl_ff[strap_cfg_pkg::CTRL_SPEED] ==
      $past(strap_sync_ff[strap_cfg_pkg::SP_SPEED]) &&
      ctrl_ff[strap_cfg_pkg::CTRL_DUPLEX] !=
      $past(strap_sync_ff[strap_cfg_pkg::SP_DUPLEX]) &&
      ctrl_ff[strap_cfg_pkg::CTRL_ANEG] ==
      $past(strap_sync_ff[strap_cfg_pkg::SP_ANEG])
  ) else $error("Control register not preloaded from straps");

  a_adv_speed_ok: assert property ( // R7
    capture && !strap_sync_ff[strap_cfg_pkg::SP_SPEED] |=>
      (adv_ff & strap_cfg_pkg::ADV_100_MASK) == '0
  ) else $error("100M ability advertised with 10M strap");

  a_nand_from_strap: assert property ( // R10
    capture ##2 1'b1 |-> nand_tree_en_o ==
      !$past(strap_sync_ff[strap_cfg_pkg::SP_NAND_N], 2)
  ) else $error("Test mode not taken from strap");

  a_pins_in_reset: assert property ( // R11
    !rstn_sync_ff |=> strap_pin_oe_o == '0 && pull_en_o
  ) else $error("Strap pins driven during chip reset");

  a_pins_released: assert property ( // R11
    capture ##1 rstn_sync_ff |=> strap_pin_oe_o == '1 && !pull_en_o
  ) else $error("Strap pins not released after capture");

endmodule : reset_strap_config_latch

// File: strap_board_model.sv
// Board side of the strap pads: pull resistors and an idle MAC.
// Assumes per-bit output enables from the device, high while it drives.
`timescale 1ns/1ps

module strap_board_model (
  input wire logic [strap_cfg_pkg::STRAP_W-1:0] pull_i,
  input wire logic [strap_cfg_pkg::STRAP_W-1:0] drive_i,
  input wire logic [strap_cfg_pkg::STRAP_W-1:0] oe_i,
  output logic [strap_cfg_pkg::STRAP_W-1:0] pad_o
);
  // ****************************************************************
  // Pad level
  // ****************************************************************
  // MAC quiet, pulls win
  // Pulls are strong enough, so an undriven pad always shows them
  assign pad_o = (oe_i & drive_i) | (~oe_i & pull_i);
endmodule : strap_board_model

// File: tb.sv
// Self-checking bench for the strap configuration latch.
// Assumes the board model on the pads and a Wishbone master here.
`timescale 1ns/1ps

module tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
  logic chip_rst_n_i = 0;
  logic [7:0] adr_i = 0;
  logic [31:0] dat_i = 0, dat_o, rd;
  logic [3:0] sel_i = 0;
  logic [11:0] pat = 12'hF11, func_i = 12'h000, pad, pin_o, oe;
  logic pull_en_o, cfg_valid_o, bcast_en_o, rmii_mode_o, b2b_mode_o;
  logic mode_reserved_o, isolate_o, speed_100_o, full_duplex_o;
  logic autoneg_en_o, nand_tree_en_o, ack_o;
  logic [4:0] mgmt_addr_o;
  int miscompares = 0, checked = 0;
  bit sw9 = 0;
  logic [11:0] q[$];
  logic [11:0] s;

  always #2.5 clk_i = ~clk_i;

  reset_strap_config_latch u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
    .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .chip_rst_n_i(chip_rst_n_i), .strap_pin_i(pad),
    .strap_pin_o(pin_o), .strap_pin_oe_o(oe), .pull_en_o(pull_en_o),
    .func_i(func_i), .cfg_valid_o(cfg_valid_o),
    .mgmt_addr_o(mgmt_addr_o), .bcast_en_o(bcast_en_o),
    .rmii_mode_o(rmii_mode_o), .b2b_mode_o(b2b_mode_o),
    .mode_reserved_o(mode_reserved_o), .isolate_o(isolate_o),
    .speed_100_o(speed_100_o), .full_duplex_o(full_duplex_o),
    .autoneg_en_o(autoneg_en_o), .nand_tree_en_o(nand_tree_en_o));

  strap_board_model u_board (.pull_i(pat), .drive_i(pin_o),
    .oe_i(oe), .pad_o(pad));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Classic cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] sl);
    int n;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= sl;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    if (n == 20) begin
      miscompares++;
      summarize();
    end
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask : wb

  task automatic expect_cfg(input logic [11:0] v);
    logic [2:0] m;
    logic rs;
    m = v[6:4];
    rs = (m != 3'h1) && (m != 3'h5);
    chk("mgmt_addr", {2'h0, v[2:0]}, mgmt_addr_o);
    chk("bcast", !v[3] && !sw9, bcast_en_o);
    chk("mode", {m == 3'h1, m == 3'h5, rs},
        {rmii_mode_o, b2b_mode_o, mode_reserved_o});
    chk("ctl_pins", {v[7], v[8], !v[9], v[10]}, {isolate_o,
        speed_100_o, full_duplex_o, autoneg_en_o});
    chk("nand", !v[11], nand_tree_en_o);
    wb(0, 8'h00, 0, 4'hF);
    chk("ctrl", {v[8], v[10], 1'b0, v[7], 1'b0, !v[9], 8'h00},
        rd);
    wb(0, 8'h10, 0, 4'hF);
    chk("adv", v[8] ? 32'h01E1 : 32'h0061, rd);
    wb(0, 8'h60, 0, 4'hF);
    chk("stat", {1'b1, rs, 2'h0, v}, rd);
  endtask : expect_cfg

  task automatic cap(input logic [11:0] v);
    int n;
    pat <= v;
    chip_rst_n_i <= 0;
    repeat (8) @(posedge clk_i);
    chk("oe_rst", 0, oe);
    chk("pull_rst", 1, pull_en_o);
    chk("valid_low", 0, cfg_valid_o);
    // capture on the rising reset pin
    chip_rst_n_i <= 1;
    for (n = 0; n < 20 && cfg_valid_o !== 1'b1; n++) @(posedge clk_i);
    if (n == 20) begin
      miscompares++;
      summarize();
    end
    repeat (2) @(posedge clk_i);
    chk("oe_run", 12'hFFF, oe);
    chk("pull_run", 0, pull_en_o);
    // Pads now carry their own function; straps must not move
    pat <= ~v;
    func_i <= 12'($urandom);
    repeat (2) @(posedge clk_i);
    chk("pad_out", func_i, pin_o);
    expect_cfg(v);
  endtask : cap

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(81));
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h00, 0, 4'hF);
    chk("ctrl_rst", 32'h3000, rd);
    wb(0, 8'h10, 0, 4'hF);
    chk("adv_rst", 32'h01E1, rd);
    wb(0, 8'h58, 0, 4'hF);
    chk("pctl_rst", 0, rd);
    wb(0, 8'h44, 0, 4'hF);
    chk("unmapped", 0, rd);
    chk("valid_rst", 0, cfg_valid_o);
    $display("test reset done");
    q.push_back(strap_cfg_pkg::STRAP_DEFAULT);
    for (int i = 0; i < 8; i++) begin
      s = 12'($urandom);
      s[6:4] = 3'(i);
      s[2:0] = 3'(7 - i);
      q.push_back(s);
    end
    foreach (q[i]) cap(q[i]);
    $display("test capture done");
    cap(12'hF10);
    wb(1, 8'h58, 32'h0200, 4'h1);
    repeat (3) @(posedge clk_i);
    chk("bcast_lane", 1, bcast_en_o);
    wb(1, 8'h58, 32'h0200, 4'h3);
    sw9 = 1;
    repeat (3) @(posedge clk_i);
    chk("bcast_sw", 0, bcast_en_o);
    wb(1, 8'h60, 32'hFFFF, 4'hF);
    wb(1, 8'h44, 32'hFFFF, 4'hF);
    wb(0, 8'h44, 0, 4'hF);
    chk("unmapped_w", 0, rd);
    expect_cfg(12'hF10);
    $display("test broadcast done");
    summarize();
  end
endmodule : tb
